//--- design/fpac_consts.svh
`ifndef FPAC_CONSTS_SVH
`define FPAC_CONSTS_SVH
// timing: clock period, panel tick, timeout, debounce and blink half periods
`define FPAC_CLK_NS 50
`define FPAC_TICK_NS 1000000
`define FPAC_TICK_CYC (`FPAC_TICK_NS / `FPAC_CLK_NS)
`define FPAC_TMO_S 15
`define FPAC_TMO_MS (`FPAC_TMO_S * 1000)
`define FPAC_DEB_MS 10
`define FPAC_SLOW_MS 500
`define FPAC_FAST_MS 125
// audio levels in dB
`define FPAC_GAIN_MIN (-70)
`define FPAC_GAIN_MAX 12
`define FPAC_PEAK_MAX 3'h5
`define FPAC_REF_HI (-18)
`define FPAC_REF_LO (-20)
`define FPAC_VU_SPAN 20
// register byte offsets
`define FPAC_OFS_CTRL 6'h00
`define FPAC_OFS_GAIN 6'h04
`define FPAC_OFS_MAP 6'h08
`define FPAC_OFS_STAT 6'h0C
// control word fields
`define FPAC_CTRL_REF 0
`define FPAC_CTRL_DIG 1
`define FPAC_CTRL_PEAK 4:2
`define FPAC_CTRL_GRP 6:5
`define FPAC_CTRL_SETUP 7
// status word fields
`define FPAC_STAT_PRES 1:0
`define FPAC_STAT_MODE 4:2
`define FPAC_STAT_DIRTY 5
`define FPAC_STAT_AUD 6
`define FPAC_STAT_LOAD 7
// reset values
`define FPAC_MAP_RST 16'h8421
`endif

//--- design/fpac_pkg.sv
package fpac_pkg;
    typedef enum logic [2:0] {M_IDLE, M_REF, M_GRP, M_G12, M_G34} fpac_mode_t;
    typedef enum logic [1:0] {P_NONE, P_525, P_625} fpac_pres_t;
    typedef enum logic [1:0] {C_OFF, C_GREEN, C_RED, C_ORANGE} fpac_color_t;
    // settings kept in non-volatile storage
    typedef struct packed {
        logic ref_lvl; // 0: -10 dBu, 1: +4 dBu
        logic dig_ref; // 0: -20 dBFS, 1: -18 dBFS
        logic [2:0] peak_sel; // 0 clipping, n: 2n dB headroom
        logic [1:0] group; // embedded group 1..4 as 0..3
        logic setup; // pedestal request
        logic [3:0][7:0] gain; // signed dB per input channel
        logic [3:0][3:0] map; // output mask per input channel
    } fpac_cfg_t;
    // video and audio output controls
    typedef struct packed {
        logic mute;
        logic pal;
        logic setup_on;
    } fpac_av_t;
    // front panel lamps
    typedef struct packed {
        fpac_color_t in;
        fpac_color_t ref_m10;
        fpac_color_t ref_p4;
        fpac_color_t [3:0] grp;
        fpac_color_t [1:0] vu;
        fpac_color_t [1:0] gain;
    } fpac_lamps_t;
    // whole state of the panel controller
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] db;
        logic [2:0] press;
        logic [2:0][3:0] dcnt;
        logic [15:0] tick_cnt;
        logic tick;
        logic [15:0] tmo_cnt;
        logic tmo_run;
        logic [8:0] slow_cnt;
        logic slow;
        logic [6:0] fast_cnt;
        logic fast;
        fpac_mode_t mode;
        fpac_cfg_t cfg;
        logic dirty;
        logic loading;
        fpac_pres_t pres;
        fpac_av_t av;
        fpac_lamps_t lamps;
        logic nv_save;
        fpac_cfg_t nvd;
        logic waitreq;
        logic [31:0] rdata;
    } fpac_state_t;
endpackage : fpac_pkg

//--- design/fpac_top.sv
// Contract
// [R1] each mode button press advances the mode by exactly one state; the code ignores presses while stored settings are still loading
// [R2] fifteen seconds without a press returns the mode to idle; the code also restarts the timer on every bus write to the settings
// [R3] right or left press steps the blinking setting up or down
// [R4] in idle all lamps except meters are steady
// [R5] reference level select mode blinks the chosen reference lamp
// [R6] group select mode blinks the chosen group lamp
// [R7] gain mode blinks fast when gain changed, slow at default
// [R8] settings saved to storage only when the timeout expires
// [R9] saved settings are reloaded from storage after power-up
// [R10] input lamp green while a valid input is locked, else dark
// [R11] exactly one reference lamp green, matching the selection
// [R12] selected group lamp green with audio, red without
// [R13] group selection offers four embedded groups
// [R14] meter lamp red when level exceeds peak headroom threshold
// [R15] meter orange above 0 VU, green above -20 VU, else dark
// [R16] gain lamp red when pair gain is not unity
// [R17] 0 VU equals the selected digital reference level
// [R18] digital reference selectable as -18 or -20 dBFS
// [R19] video and audio muted when the input is lost
// [R20] encoder follows detected 525 or 625 line standard
// [R21] four channels with per-channel gain and output mapping
// [R22] setup pedestal acts only in 525 line operation
// [R23] peak threshold clipping or 2, 4, 6, 8, 10 dB
// [R24] channel gain in dB steps from -70 to +12
// [R25] input status is none, 525 locked or 625 locked
// [R26] mode order idle, reference, group, gain 1/2, gain 3/4, idle
// [R27] buttons debounced and edge detected, one press one event
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "fpac_consts.svh"

module fpac_top
    import fpac_pkg::*;
#(
    parameter int TICK_CYC = `FPAC_TICK_CYC, // clock cycles per 1 ms tick
    parameter int TMO_MS = `FPAC_TMO_MS // inactivity timeout in ms
) (
    input wire logic mclk_i, // 20 MHz clock
    input wire logic resetn_i, // async reset, active low
    input wire logic btn_mode_n_i, // mode button pin, low when pressed
    input wire logic btn_right_n_i, // right arrow pin, low when pressed
    input wire logic btn_left_n_i, // left arrow pin, low when pressed
    input wire logic sdi_lock_i, // receiver locked to a valid input
    input wire logic sdi_625_i, // receiver sees 625 lines
    input wire logic [3:0] grp_audio_i, // audio present per group
    input wire logic [1:0][7:0] lvl_i, // signed dBFS level per pair
    input wire logic nv_valid_i, // stored settings available
    input wire fpac_cfg_t nv_data_i, // stored settings
    input wire logic [5:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    output fpac_lamps_t lamps_o, // lamp colours
    output fpac_av_t av_o, // mute, standard, pedestal
    output fpac_cfg_t cfg_o, // live settings
    output fpac_pres_t pres_o, // input presence
    output logic nv_save_o, // store pulse
    output fpac_cfg_t nv_data_o // settings to store
);

    ////////////////////////////////////////////////////////////////
    fpac_state_t st;
    fpac_state_t next_st;
    logic tmo_hit;
    logic bus_cfg_wr;
    logic [5:0] ofs;

    // successor in the mode sequence
    function automatic fpac_mode_t mode_succ(input fpac_mode_t m);
        case (m) // [R26]
            M_IDLE: return M_REF;
            M_REF: return M_GRP;
            M_GRP: return M_G12;
            M_G12: return M_G34;
            default: return M_IDLE;
        endcase
    endfunction : mode_succ

    // limit a gain to its legal range
    function automatic logic [7:0] gain_clamp(input logic [7:0] g);
        if ($signed(g) < $signed(8'(`FPAC_GAIN_MIN))) begin
            return 8'(`FPAC_GAIN_MIN); // [R24]
        end
        if ($signed(g) > $signed(8'(`FPAC_GAIN_MAX))) begin
            return 8'(`FPAC_GAIN_MAX); // [R24]
        end
        return g;
    endfunction : gain_clamp

    // one dB step up or down, held at the ends
    function automatic logic [7:0] gain_step(input logic [7:0] g, input logic up);
        if (up && $signed(g) < $signed(8'(`FPAC_GAIN_MAX))) begin
            return g + 8'h01; // [R24]
        end
        if (!up && $signed(g) > $signed(8'(`FPAC_GAIN_MIN))) begin
            return g - 8'h01; // [R24]
        end
        return g;
    endfunction : gain_step

    // force every field into its legal range
    function automatic fpac_cfg_t cfg_fix(input fpac_cfg_t c);
        fpac_cfg_t r;
        r = c;
        if (c.peak_sel > `FPAC_PEAK_MAX) begin
            r.peak_sel = `FPAC_PEAK_MAX; // [R23]
        end
        for (int i = 0; i < 4; i++) begin
            r.gain[i] = gain_clamp(c.gain[i]);
        end
        return r;
    endfunction : cfg_fix

    // control word view of the settings
    function automatic logic [31:0] ctrl_word(input fpac_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[`FPAC_CTRL_REF] = c.ref_lvl;
        w[`FPAC_CTRL_DIG] = c.dig_ref;
        w[`FPAC_CTRL_PEAK] = c.peak_sel;
        w[`FPAC_CTRL_GRP] = c.group;
        w[`FPAC_CTRL_SETUP] = c.setup;
        return w;
    endfunction : ctrl_word

    // apply enabled byte lanes of a write
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i+:8] = wd[8*i+:8];
            end
        end
        return r;
    endfunction : be_merge

    // meter colour from level, headroom and digital reference
    function automatic fpac_color_t vu_color(input logic [7:0] lv, input fpac_cfg_t c);
        logic signed [7:0] pk;
        logic signed [7:0] rf;
        logic signed [7:0] lo;
        pk = 8'sh00 - $signed({4'h0, c.peak_sel, 1'b0}); // [R23]
        rf = c.dig_ref ? $signed(8'(`FPAC_REF_HI)) : $signed(8'(`FPAC_REF_LO)); // [R17] [R18]
        lo = rf - $signed(8'(`FPAC_VU_SPAN));
        if ($signed(lv) >= pk) begin
            return C_RED; // [R14]
        end
        if ($signed(lv) > rf) begin
            return C_ORANGE; // [R15]
        end
        if ($signed(lv) > lo) begin
            return C_GREEN; // [R15]
        end
        return C_OFF;
    endfunction : vu_color

    ////////////////////////////////////////////////////////////////
    // bus decode and timeout condition
    assign ofs = {avs_address_i[5:2], 2'b00};
    assign bus_cfg_wr = avs_write_i && !st.waitreq &&
        (ofs == `FPAC_OFS_CTRL || ofs == `FPAC_OFS_GAIN || ofs == `FPAC_OFS_MAP);
    assign tmo_hit = st.tick && st.tmo_run && st.tmo_cnt == 16'(TMO_MS - 1) &&
        !(|st.press) && !bus_cfg_wr; // [R2]

    ////////////////////////////////////////////////////////////////
    // next state of the whole controller
    always_comb begin
        int gi;
        logic changed;
        logic blink_on;
        logic [31:0] w;
        gi = 0;
        changed = 1'b0;
        blink_on = 1'b0;
        w = 32'h00000000;
        next_st = st;
        next_st.tick = 1'b0;
        next_st.press = 3'h0;
        next_st.nv_save = 1'b0;
        // pin synchronisers, bit 0 mode, 1 right, 2 left
        next_st.s1 = ~{btn_left_n_i, btn_right_n_i, btn_mode_n_i};
        next_st.s2 = st.s1;
        // 1 ms tick divider
        if (st.tick_cnt == 16'(TICK_CYC - 1)) begin
            next_st.tick_cnt = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 16'h0001;
        end
        // debounce, press pulse on a settled rising edge
        for (int b = 0; b < 3; b++) begin
            if (st.s2[b] == st.db[b]) begin
                next_st.dcnt[b] = 4'h0;
            end else if (st.tick) begin
                if (st.dcnt[b] == 4'(`FPAC_DEB_MS - 1)) begin
                    next_st.dcnt[b] = 4'h0;
                    next_st.db[b] = st.s2[b];
                    next_st.press[b] = st.s2[b]; // [R27]
                end else begin
                    next_st.dcnt[b] = st.dcnt[b] + 4'h1;
                end
            end
        end
        // slow and fast blink phases
        if (st.tick) begin
            if (st.slow_cnt == 9'(`FPAC_SLOW_MS - 1)) begin
                next_st.slow_cnt = 9'h000;
                next_st.slow = !st.slow;
            end else begin
                next_st.slow_cnt = st.slow_cnt + 9'h001;
            end
            if (st.fast_cnt == 7'(`FPAC_FAST_MS - 1)) begin
                next_st.fast_cnt = 7'h00;
                next_st.fast = !st.fast;
            end else begin
                next_st.fast_cnt = st.fast_cnt + 7'h01;
            end
        end
        // inactivity timer, save only on expiry
        if (|st.press || bus_cfg_wr) begin
            next_st.tmo_cnt = 16'h0000;
            next_st.tmo_run = 1'b1;
        end else if (tmo_hit) begin
            next_st.tmo_run = 1'b0;
            next_st.mode = M_IDLE; // [R2]
            next_st.nv_save = st.dirty; // [R8]
            next_st.nvd = st.cfg; // [R8]
            next_st.dirty = 1'b0;
        end else if (st.tick && st.tmo_run) begin
            next_st.tmo_cnt = st.tmo_cnt + 16'h0001;
        end
        // panel buttons, ignored until settings are restored
        if (!st.loading) begin
            if (st.press[0]) begin
                next_st.mode = mode_succ(st.mode); // [R1]
            end else if (st.press[1] || st.press[2]) begin
                case (st.mode) // [R3]
                    M_REF: begin
                        next_st.cfg.ref_lvl = !st.cfg.ref_lvl;
                        next_st.dirty = 1'b1;
                    end
                    M_GRP: begin
                        next_st.cfg.group = st.press[1] ? st.cfg.group + 2'h1 : st.cfg.group - 2'h1; // [R13]
                        next_st.dirty = 1'b1;
                    end
                    M_G12, M_G34: begin
                        for (int c = 0; c < 2; c++) begin
                            gi = (st.mode == M_G34) ? c + 2 : c;
                            next_st.cfg.gain[gi] = gain_step(st.cfg.gain[gi], st.press[1]);
                        end
                        next_st.dirty = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
        // restore stored settings after power-up
        if (st.loading && nv_valid_i) begin
            next_st.cfg = cfg_fix(nv_data_i); // [R9]
            next_st.loading = 1'b0;
            next_st.dirty = 1'b0;
        end
        // input status and output controls
        next_st.pres = !sdi_lock_i ? P_NONE : (sdi_625_i ? P_625 : P_525); // [R25]
        next_st.av.mute = !sdi_lock_i; // [R19]
        if (sdi_lock_i) begin
            next_st.av.pal = sdi_625_i; // [R20]
        end
        next_st.av.setup_on = st.cfg.setup && sdi_lock_i && !sdi_625_i; // [R22]
        // input and reference lamps
        next_st.lamps.in = (st.pres != P_NONE) ? C_GREEN : C_OFF; // [R10]
        blink_on = (st.mode != M_REF) || st.slow; // [R4] [R5]
        next_st.lamps.ref_m10 = (!st.cfg.ref_lvl && blink_on) ? C_GREEN : C_OFF; // [R11]
        next_st.lamps.ref_p4 = (st.cfg.ref_lvl && blink_on) ? C_GREEN : C_OFF; // [R11]
        // group lamps
        blink_on = (st.mode != M_GRP) || st.slow; // [R6]
        for (int g = 0; g < 4; g++) begin
            if (st.cfg.group == 2'(g) && blink_on) begin
                next_st.lamps.grp[g] = grp_audio_i[g] ? C_GREEN : C_RED; // [R12]
            end else begin
                next_st.lamps.grp[g] = C_OFF;
            end
        end
        // meter and gain lamps per pair
        for (int p = 0; p < 2; p++) begin
            next_st.lamps.vu[p] = vu_color(lvl_i[p], st.cfg); // [R14] [R15]
            changed = (st.cfg.gain[2*p] != 8'h00) || (st.cfg.gain[2*p+1] != 8'h00);
            if (st.mode == (p == 0 ? M_G12 : M_G34)) begin
                blink_on = changed ? st.fast : st.slow; // [R7]
                next_st.lamps.gain[p] = !blink_on ? C_OFF : (changed ? C_RED : C_GREEN);
            end else begin
                next_st.lamps.gain[p] = changed ? C_RED : C_OFF; // [R16]
            end
        end
        // bus slave, one wait cycle then the transfer completes
        if ((avs_read_i || avs_write_i) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            case (ofs)
                `FPAC_OFS_CTRL: next_st.rdata = ctrl_word(st.cfg);
                `FPAC_OFS_GAIN: next_st.rdata = st.cfg.gain;
                `FPAC_OFS_MAP: next_st.rdata = {16'h0000, st.cfg.map};
                `FPAC_OFS_STAT: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rdata[`FPAC_STAT_PRES] = st.pres;
                    next_st.rdata[`FPAC_STAT_MODE] = st.mode;
                    next_st.rdata[`FPAC_STAT_DIRTY] = st.dirty;
                    next_st.rdata[`FPAC_STAT_AUD] = grp_audio_i[st.cfg.group];
                    next_st.rdata[`FPAC_STAT_LOAD] = st.loading;
                end
                default: next_st.rdata = 32'h00000000;
            endcase
        end else if (!st.waitreq) begin
            next_st.waitreq = 1'b1;
        end
        // bus writes to settings, last so they win
        if (bus_cfg_wr) begin
            case (ofs)
                `FPAC_OFS_CTRL: begin
                    w = be_merge(ctrl_word(st.cfg), avs_writedata_i, avs_byteenable_i);
                    next_st.cfg.ref_lvl = w[`FPAC_CTRL_REF];
                    next_st.cfg.dig_ref = w[`FPAC_CTRL_DIG]; // [R18]
                    next_st.cfg.peak_sel = w[`FPAC_CTRL_PEAK];
                    next_st.cfg.group = w[`FPAC_CTRL_GRP];
                    next_st.cfg.setup = w[`FPAC_CTRL_SETUP];
                end
                `FPAC_OFS_GAIN: begin
                    next_st.cfg.gain = be_merge(st.cfg.gain, avs_writedata_i, avs_byteenable_i); // [R21]
                end
                default: begin
                    w = be_merge({16'h0000, st.cfg.map}, avs_writedata_i, avs_byteenable_i);
                    next_st.cfg.map = w[15:0]; // [R21]
                end
            endcase
            next_st.cfg = cfg_fix(next_st.cfg);
            next_st.dirty = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.waitreq <= 1'b1;
            st.loading <= 1'b1;
            st.cfg.map <= `FPAC_MAP_RST;
            st.lamps.ref_m10 <= C_GREEN; // [R11] reset selection is -10 dBu, its lamp lit at once
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign lamps_o = st.lamps;
    assign av_o = st.av;
    assign cfg_o = st.cfg;
    assign pres_o = st.pres;
    assign nv_save_o = st.nv_save;
    assign nv_data_o = st.nvd;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_expire;
        tmo_hit && st.dirty;
    endsequence
    sequence s_save_pulse;
        st.nv_save ##1 !st.nv_save;
    endsequence

    property p_mode_step;
        st.press[0] && !st.loading |=> st.mode == mode_succ($past(st.mode));
    endproperty
    a_mode_step: assert property (p_mode_step) else $error("mode did not advance"); // [R1]

    property p_timeout;
        tmo_hit |=> st.mode == M_IDLE && !st.tmo_run;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout left mode"); // [R2]

    property p_grp_step;
        st.press[1] && !st.press[0] && st.mode == M_GRP && !st.loading && !bus_cfg_wr
        |=> st.cfg.group == $past(st.cfg.group) + 2'h1;
    endproperty
    a_grp_step: assert property (p_grp_step) else $error("group did not step"); // [R3]

    property p_idle_steady;
        (st.mode == M_IDLE && !bus_cfg_wr && !st.loading) [*3]
        |-> $stable(lamps_o.ref_m10) && $stable(lamps_o.ref_p4);
    endproperty
    a_idle_steady: assert property (p_idle_steady) else $error("idle lamp changed"); // [R4]

    property p_ref_blink;
        st.mode == M_REF && !st.slow |=> lamps_o.ref_m10 == C_OFF && lamps_o.ref_p4 == C_OFF;
    endproperty
    a_ref_blink: assert property (p_ref_blink) else $error("reference lamp not blinking"); // [R5]

    property p_grp_blink;
        st.mode == M_GRP && !st.slow |=> lamps_o.grp[st.cfg.group] == C_OFF;
    endproperty
    a_grp_blink: assert property (p_grp_blink) else $error("group lamp not blinking"); // [R6]

    property p_gain_fast;
        st.mode == M_G12 && st.cfg.gain[0] != 8'h00
        |=> lamps_o.gain[0] == ($past(st.fast) ? C_RED : C_OFF);
    endproperty
    a_gain_fast: assert property (p_gain_fast) else $error("gain lamp not fast"); // [R7]

    property p_save;
        s_expire |=> s_save_pulse;
    endproperty
    a_save: assert property (p_save) else $error("no save on timeout"); // [R8]

    property p_no_save;
        st.nv_save |-> $past(tmo_hit);
    endproperty
    a_no_save: assert property (p_no_save) else $error("save without timeout"); // [R8]

    property p_restore;
        st.loading && nv_valid_i && !bus_cfg_wr |=> !st.loading && !st.dirty;
    endproperty
    a_restore: assert property (p_restore) else $error("restore not done"); // [R9]

    property p_ref_one;
        st.mode == M_IDLE |=> (lamps_o.ref_m10 == C_GREEN) != (lamps_o.ref_p4 == C_GREEN);
    endproperty
    a_ref_one: assert property (p_ref_one) else $error("reference lamps wrong"); // [R11]

    property p_peak;
        resetn_i && $signed(lvl_i[0]) >= 0 |=> lamps_o.vu[0] == C_RED;
    endproperty
    a_peak: assert property (p_peak) else $error("clip not red"); // [R14]

    property p_mute;
        av_o.mute == !$past(sdi_lock_i);
    endproperty
    a_mute: assert property (p_mute) else $error("mute does not follow loss"); // [R19]

    property p_setup;
        av_o.setup_on |-> !av_o.pal && !av_o.mute;
    endproperty
    a_setup: assert property (p_setup) else $error("setup outside 525"); // [R22]

endmodule : fpac_top
`default_nettype wire

//--- dv/fpac_panel.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module fpac_panel (
    input wire logic mclk_i, // panel clock
    output logic [2:0] btn_n_o // mode, right, left pins
);
    // released pins sit at the pull-up level
    initial btn_n_o = 3'h7;
    // hold low well past the debounce time, then release as long
    task automatic press(input int b);
        @(posedge mclk_i);
        btn_n_o[b] <= 1'b0;
        repeat (60) @(posedge mclk_i);
        btn_n_o[b] <= 1'b1;
        repeat (60) @(posedge mclk_i);
    endtask : press
endmodule : fpac_panel
`default_nettype wire

//--- dv/front_panel_audio_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module front_panel_audio_control_test
    import fpac_pkg::*;
;
    logic mclk_i = 1'b0, resetn_i = 1'b0, lock = 1'b1, s625 = 1'b0, nvv = 1'b0;
    logic rd = 1'b0, wr = 1'b0, wq, sav;
    logic [3:0] gaud = 4'h5, be = 4'hF;
    logic [1:0][7:0] lvl = '0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0, q, r;
    logic [2:0] btn;
    logic [7:0] lv[5] = '{8'h00, 8'hFE, 8'hFD, 8'hED, 8'hD9};
    fpac_color_t vc[5] = '{C_RED, C_RED, C_ORANGE, C_GREEN, C_OFF};
    fpac_cfg_t nvd = '0, cfg, nvo, sv;
    fpac_lamps_t lmp;
    fpac_av_t av;
    fpac_pres_t pres;
    int bad_count = 0, comparisons = 0, cyc = 0, saves = 0, n0;
    ////////////////////////////////////////
    fpac_top #(.TICK_CYC(4), .TMO_MS(50)) dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .btn_mode_n_i(btn[0]), .btn_right_n_i(btn[1]),
        .btn_left_n_i(btn[2]), .sdi_lock_i(lock), .sdi_625_i(s625), .grp_audio_i(gaud), .lvl_i(lvl),
        .nv_valid_i(nvv), .nv_data_i(nvd), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(q), .avs_waitrequest_o(wq),
        .lamps_o(lmp), .av_o(av), .cfg_o(cfg), .pres_o(pres), .nv_save_o(sav), .nv_data_o(nvo));
    fpac_panel pm (.mclk_i(mclk_i), .btn_n_o(btn));
    initial forever #25 mclk_i = ~mclk_i;
    // hang limit and capture of store pulses
    always @(posedge mclk_i) begin
        cyc++;
        if (sav === 1'b1) begin
            saves++;
            sv = nvo;
        end
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] v);
        @(posedge mclk_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge mclk_i);
        end while (wq !== 1'b0);
        v = q;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask : rdchk
    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial begin
        nvd.ref_lvl = 1'b1;
        nvd.group = 2'h2;
        nvd.map = 16'h1248;
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rdchk(6'h0C, 32'h000000C1);
        rdchk(6'h10, 32'h00000000);
        nvv <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rdchk(6'h00, 32'h00000041);
        rdchk(6'h08, 32'h00001248);
        chk(lmp.ref_p4, C_GREEN);
        chk(lmp.ref_m10, C_OFF);
        for (int g = 0; g < 4; g++) begin
            bus(1'b1, 6'h00, 32'(g) << 5, r);
            repeat (3) @(posedge mclk_i);
            chk(lmp.grp[g], gaud[g] ? C_GREEN : C_RED);
        end
        chk(lmp.ref_m10, C_GREEN);
        gaud <= 4'hA;
        repeat (3) @(posedge mclk_i);
        chk(lmp.grp[3], C_GREEN);
        bus(1'b1, 6'h00, 32'h00000006, r);
        for (int i = 0; i < 5; i++) begin
            lvl[0] <= lv[i];
            repeat (4) @(posedge mclk_i);
            chk(lmp.vu[0], vc[i]);
        end
        for (int i = 1; i <= 5; i++) begin
            pm.press(0);
            bus(1'b0, 6'h0C, 32'h0, r);
            chk(r[4:2], i % 5);
            if (i == 1 || i == 3) pm.press(1);
            if (i == 2) begin
                pm.press(1);
                chk(cfg.group, 2'h1);
                pm.press(2);
                chk(cfg.group, 2'h0);
            end
            if (i == 1) chk(cfg.ref_lvl, 1'b1);
            if (i == 3) chk(cfg.gain[0], 8'h01);
        end
        chk(lmp.gain[0], C_RED);
        chk(lmp.gain[1], C_OFF);
        n0 = saves;
        pm.press(0);
        chk(saves, n0);
        for (int k = 0; k < 400 && saves == n0; k++) @(posedge mclk_i);
        chk(saves, n0 + 1);
        chk(sv.gain[0], 8'h01);
        chk(sv.ref_lvl, 1'b1);
        bus(1'b0, 6'h0C, 32'h0, r);
        chk(r[4:2], 0);
        lock <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(av.mute, 1'b1);
        chk(lmp.in, C_OFF);
        chk(pres, P_NONE);
        s625 <= 1'b1;
        lock <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk(av, 3'h2);
        chk(lmp.in, C_GREEN);
        chk(pres, P_625);
        bus(1'b1, 6'h00, 32'h00000080, r);
        repeat (2) @(posedge mclk_i);
        chk(av.setup_on, 1'b0);
        s625 <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(av, 3'h1);
        be <= 4'h6;
        bus(1'b1, 6'h04, 32'h00200500, r);
        be <= 4'hF;
        rdchk(6'h04, 32'h000C0501);
        tally_and_finish();
    end
endmodule : front_panel_audio_control_test
`default_nettype wire
